/* File: logic/dsj_regfile.sv */
/*
 * one general register file: sixteen 32-bit words, async reset to zero,
 * one registered read port, one write port and one loader write port.
 * assumes the caller applies read address one cycle before using data.
 */
`timescale 1ns/1ps
`default_nettype none
module dsj_regfile #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4,
    parameter int unsigned DW    = 32
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic          i_init_we,
    input  wire logic [AW-1:0] i_init_addr,
    input  wire logic [DW-1:0] i_init_data
);
    logic [DW-1:0] mem_q [DEPTH];

    // ========================================================
    // storage; the unit's own write wins over the loader port
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
        end
        else if (i_we)
            mem_q[i_waddr] <= i_wdata;
        else if (i_init_we)
            mem_q[i_init_addr] <= i_init_data;
    end

    // registered read keeps the data output off the array mux
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= '0;
        else
            o_rdata <= mem_q[i_raddr];
    end
endmodule
`default_nettype wire

/* File: logic/dsj_unit.sv */
/*
 * execution unit for the three decrement-and-skip-jump loop instructions,
 * holding two general register files it decrements in place.
 * assumes the fetch side presents one 16-bit word per i_word_valid pulse,
 * the second word of a long form following the first, and i_pc giving the
 * bit address of the first word. status flags are inputs only.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1 - the nonzero-flag-clear long form decrements only when zero flag is clear.
// RULE2 - with zero flag set that form leaves the register alone and falls through.
// RULE3 - after decrementing, a nonzero result branches and zero falls through.
// RULE4 - long forms take as base the address after their second word.
// RULE5 - long forms scale the word offset by 16 and add it to that base.
// RULE6 - the whole second word is a signed offset of -32768 to +32767 words.
// RULE7 - the first word holds the opcode in bits 15..5, file in 4, register in 3..0.
// RULE8 - the short form always decrements, regardless of flags.
// RULE9 - the short form branches on a nonzero result and otherwise falls through.
// RULE10 - short word holds direction in 10, offset in 9..5, file in 4, reg in 3..0.
// RULE11 - direction clear means forward and set means backward.
// RULE12 - forward short target is base plus offset times sixteen.
// RULE13 - backward short target is base minus offset times sixteen.
// RULE14 - short base is the word after the instruction, reach -30 to +32 words.
// RULE15 - the zero-flag-set long form acts only when zero flag is set, else skips.
// RULE16 - no status flag changes, and zero decrements to all ones, which branches.
// RULE17 - the file bit picks the register file and the index reads and writes back.
module dsj_unit
    import dsj_pkg::*;
(
    input  wire logic                        i_clk,
    input  wire logic                        i_nrst,
    input  wire logic                        i_word_valid,
    input  wire logic [dsj_pkg::WORD_W-1:0]  i_word,
    input  wire logic [dsj_pkg::PC_W-1:0]    i_pc,
    input  wire logic                        i_zero_flag,
    input  wire logic                        i_init_we,
    input  wire logic                        i_init_file,
    input  wire logic [dsj_pkg::REG_IDX_W-1:0] i_init_idx,
    input  wire logic [dsj_pkg::DATA_W-1:0]  i_init_data,
    output logic                             o_busy,
    output logic                             o_done,
    output logic                             o_illegal,
    output logic                             o_taken,
    output logic [dsj_pkg::PC_W-1:0]         o_next_pc,
    output logic                             o_wb_valid,
    output logic                             o_wb_file,
    output logic [dsj_pkg::REG_IDX_W-1:0]    o_wb_idx,
    output logic [dsj_pkg::DATA_W-1:0]       o_wb_data
);
    import dsj_pkg::*;

    // ========================================================
    // reset release
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // ========================================================
    // decode of the incoming word
    logic [$bits(OPC_LONG_NE)-1:0] long_opc;
    logic [$bits(OPC_SHORT)-1:0]   short_opc;
    logic        is_long_ne;
    logic        is_long_eq;
    logic        is_short;

    // opcode field compares
    assign long_opc   = i_word[WORD_W-1:LONG_OPC_LSB]; // RULE7
    assign short_opc  = i_word[WORD_W-1:SHORT_OPC_LSB]; // RULE10
    assign is_long_ne = (long_opc == OPC_LONG_NE); // RULE7
    assign is_long_eq = (long_opc == OPC_LONG_EQ);
    assign is_short   = (short_opc == OPC_SHORT);

    // ========================================================
    // captured instruction
    state_e                 state_q;
    logic                   long_q;
    logic                   eq_form_q;
    logic                   act_q;
    logic                   dir_q;
    logic [SHORT_OFS_W-1:0] sofs_q;
    logic [WORD_W-1:0]      lofs_q;
    logic                   file_q;
    logic [REG_IDX_W-1:0]   idx_q;
    logic [PC_W-1:0]        base_q;
    logic                   zero_q;

    // sequencer: idle -> (offset word for long forms) -> exec
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (i_word_valid && (is_long_ne || is_long_eq))
                        state_q <= ST_OFFSET;
                    else if (i_word_valid && is_short)
                        state_q <= ST_EXEC;
                ST_OFFSET:
                    if (i_word_valid)
                        state_q <= ST_EXEC;
                ST_EXEC:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // first word fields, flag sampled with the opcode word
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            long_q    <= 1'b0;
            eq_form_q <= 1'b0;
            dir_q     <= 1'b0;
            sofs_q    <= '0;
            file_q    <= 1'b0;
            idx_q     <= '0;
            zero_q    <= 1'b0;
        end
        else if (state_q == ST_IDLE && i_word_valid)
        begin
            long_q    <= is_long_ne || is_long_eq;
            eq_form_q <= is_long_eq;
            dir_q     <= i_word[DIR_BIT]; // RULE10
            sofs_q    <= i_word[SOFS_LSB +: SHORT_OFS_W]; // RULE10
            file_q    <= i_word[FILE_BIT]; // RULE7 RULE17
            idx_q     <= i_word[RIDX_LSB +: REG_IDX_W]; // RULE7 RULE17
            zero_q    <= i_zero_flag;
        end
    end

    // whether the decrement happens at all
    always_comb
    begin
        if (!long_q)
            act_q = 1'b1; // RULE8
        else if (eq_form_q)
            act_q = zero_q; // RULE15
        else
            act_q = !zero_q; // RULE1 RULE2
    end

    // base is the word after the last instruction word
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_q <= '0;
            lofs_q <= '0;
        end
        else if (state_q == ST_IDLE && i_word_valid)
            base_q <= i_pc + WORD_BITS; // RULE14
        else if (state_q == ST_OFFSET && i_word_valid)
        begin
            base_q <= base_q + WORD_BITS; // RULE4
            lofs_q <= i_word; // RULE6
        end
    end

    // ========================================================
    // register files; the read is issued with the first word
    logic [DATA_W-1:0] rdata [NUM_FILES];
    logic [DATA_W-1:0] cur;
    logic [DATA_W-1:0] dec;
    logic [DATA_W-1:0] hold_q;
    logic              exec_we;
    logic              rd_pend_q;

    for (genvar f = 0; f < NUM_FILES; f++)
    begin : g_file
        dsj_regfile #(
            .DEPTH (NUM_REGS),
            .AW    (REG_IDX_W),
            .DW    (DATA_W)
        ) u_file (
            .i_clk       (i_clk),
            .i_rst_n     (rst_n),
            .i_raddr     (i_word[RIDX_LSB +: REG_IDX_W]),
            .o_rdata     (rdata[f]),
            .i_we        (exec_we && (file_q == 1'(f))), // RULE17
            .i_waddr     (idx_q),
            .i_wdata     (dec),
            .i_init_we   (i_init_we && (i_init_file == 1'(f))),
            .i_init_addr (i_init_idx),
            .i_init_data (i_init_data)
        );
    end

    // capture read data the cycle after the first word, since the read
    // port keeps following i_word during the wait for the offset word
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_pend_q <= 1'b0;
        else
            rd_pend_q <= (state_q == ST_IDLE) && i_word_valid;
    end

    // a long form may wait several cycles for its offset word, so the
    // register value is parked here once and read from here at exec
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            hold_q <= '0;
        else if (rd_pend_q)
            hold_q <= rdata[file_q]; // RULE17
    end

    // short form with no offset word reads straight from the port
    assign cur = rd_pend_q ? rdata[file_q] : hold_q;
    // wraps 0 to all ones, which then counts as nonzero
    assign dec = cur - ONE; // RULE16
    // an init write to the same file that lands in the exec cycle loses to this write
    assign exec_we = (state_q == ST_EXEC) && act_q; // RULE1 RULE8 RULE15

    // ========================================================
    // branch target
    logic [PC_W-1:0] lofs_bits;
    logic [PC_W-1:0] sofs_bits;
    logic [PC_W-1:0] target;
    logic            taken;

    // sign-extend the long offset, zero-extend the short one, then scale words to bits
    assign lofs_bits = {{(PC_W-WORD_W){lofs_q[WORD_W-1]}}, lofs_q}
                       << WORD_SHIFT; // RULE5 RULE6
    assign sofs_bits = {{(PC_W-SHORT_OFS_W){1'b0}}, sofs_q} << WORD_SHIFT;

    always_comb
    begin
        if (long_q)
            target = base_q + lofs_bits; // RULE5
        else if (dir_q)
            target = base_q - sofs_bits; // RULE11 RULE13
        else
            target = base_q + sofs_bits; // RULE11 RULE12
    end

    // branch on nonzero result only when the decrement happened
    assign taken = act_q && (dec != ZERO); // RULE3 RULE9 RULE2

    // ========================================================
    // result outputs, registered; flags are never driven here
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_done     <= 1'b0;
            o_taken    <= 1'b0;
            o_next_pc  <= '0;
            o_wb_valid <= 1'b0;
            o_wb_file  <= 1'b0;
            o_wb_idx   <= '0;
            o_wb_data  <= '0;
        end
        else
        begin
            o_done     <= (state_q == ST_EXEC);
            o_wb_valid <= exec_we;
            if (state_q == ST_EXEC)
            begin
                o_taken   <= taken;
                o_next_pc <= taken ? target : base_q; // RULE2 RULE3 RULE9
                o_wb_file <= file_q;
                o_wb_idx  <= idx_q;
                o_wb_data <= act_q ? dec : cur; // RULE2 RULE16
            end
        end
    end

    // words that are none of the three forms are flagged, not executed;
    // such a word still loads the field registers, which is harmless as
    // nothing acts on them before a real first word overwrites them
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_illegal <= 1'b0;
        else
            o_illegal <= (state_q == ST_IDLE) && i_word_valid
                         && !(is_long_ne || is_long_eq || is_short);
    end

    assign o_busy = (state_q != ST_IDLE);
endmodule
`default_nettype wire

/* File: shared/dsj_pkg.sv */
/*
 * constants for the decrement-skip-jump execution unit: opcode patterns,
 * field positions, widths and register file geometry.
 * assumes 16-bit instruction words and bit-addressed program counter.
 */
`default_nettype none
package dsj_pkg;
    // ========================================================
    // geometry
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned PC_W        = 32;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned REG_IDX_W   = 4;
    localparam int unsigned NUM_REGS    = 16;
    localparam int unsigned NUM_FILES   = 2;
    localparam int unsigned SHORT_OFS_W = 5;
    // bits per instruction word, also the word-to-bit offset scale
    localparam logic [PC_W-1:0] WORD_BITS = 32'h0000_0010;
    localparam int unsigned WORD_SHIFT  = 4;

    // ========================================================
    // long form first word, bits 15..5
    localparam logic [10:0] OPC_LONG_NE = 11'h06e;
    localparam logic [10:0] OPC_LONG_EQ = 11'h06d;
    localparam int unsigned LONG_OPC_LSB = 5;
    // short form, bits 15..11
    localparam logic [4:0]  OPC_SHORT   = 5'h07;
    localparam int unsigned SHORT_OPC_LSB = 11;

    // ========================================================
    // field positions
    localparam int unsigned DIR_BIT     = 10;
    localparam int unsigned SOFS_LSB    = 5;
    localparam int unsigned FILE_BIT    = 4;
    localparam int unsigned RIDX_LSB    = 0;

    localparam logic [DATA_W-1:0] ONE   = 32'h0000_0001;
    localparam logic [DATA_W-1:0] ZERO  = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OFFSET,
        ST_EXEC
    } state_e;
endpackage
`default_nettype wire

/* File: sim/dsj_unit_assertions.sv */
/*
 * checker for dsj_unit: answer timing, decrement and flow relations.
 * assumes the offset word of a long form follows its first word.
 */
`timescale 1ns/1ps
`default_nettype none
module dsj_unit_checker
    import dsj_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_word_valid,
    input wire logic [15:0] i_word,
    input wire logic [31:0] i_pc,
    input wire logic        i_zero_flag,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        o_illegal,
    input wire logic        o_taken,
    input wire logic [31:0] o_next_pc,
    input wire logic        o_wb_valid,
    input wire logic [31:0] o_wb_data
);
    // ========================================================
    // accepted first words, by form
    wire logic go = i_word_valid && !o_busy;
    wire logic go_s = go && i_word[15:11] == OPC_SHORT;
    wire logic go_ne = go && i_word[15:5] == OPC_LONG_NE;
    wire logic go_eq = go && i_word[15:5] == OPC_LONG_EQ;
    wire logic go_l = go_ne || go_eq;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    // ========================================================
    // properties
    a_short_dec: assert property (go_s |-> ##2 o_done && o_wb_valid)
        else $error("short form did not decrement in time");
    a_long_ne_dec: assert property (go_ne && !i_zero_flag ##1 i_word_valid
        |-> ##2 o_done && o_wb_valid)
        else $error("long clear form did not decrement");
    a_ne_skip: assert property (go_ne && i_zero_flag ##1 i_word_valid
        |-> ##2 o_done && !o_wb_valid && !o_taken)
        else $error("long clear form acted with zero set");
    a_eq_skip: assert property (go_eq && !i_zero_flag ##1 i_word_valid
        |-> ##2 o_done && !o_wb_valid && !o_taken)
        else $error("long set form acted with zero clear");
    a_take_nonzero: assert property (o_done && o_wb_valid
        |-> o_taken == (o_wb_data != 32'h0))
        else $error("branch does not follow decremented value");
    a_short_base: assert property (go_s |-> ##2
        (o_taken || o_next_pc == $past(i_pc, 2) + 32'h10))
        else $error("short fall through address wrong");
    a_long_base: assert property (go_l ##1 i_word_valid |-> ##2
        (o_taken || o_next_pc == $past(i_pc, 3) + 32'h20))
        else $error("long fall through address wrong");
    a_done_pulse: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    a_pc_stands: assert property (!o_done |-> $stable(o_next_pc))
        else $error("next pc changed without done");
    a_illegal_word: assert property (go && !go_s && !go_l
        |-> ##[1:2] o_illegal)
        else $error("unknown word not flagged");
    a_legal_quiet: assert property (go_s || go_l |=> !o_illegal)
        else $error("known form flagged as illegal");
endmodule

bind dsj_unit dsj_unit_checker u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_word_valid(i_word_valid), .i_word(i_word), .i_pc(i_pc),
    .i_zero_flag(i_zero_flag), .o_busy(o_busy), .o_done(o_done),
    .o_illegal(o_illegal), .o_taken(o_taken), .o_next_pc(o_next_pc),
    .o_wb_valid(o_wb_valid), .o_wb_data(o_wb_data));
`default_nettype wire

/* File: sim/dsj_unit_tb_top.sv */
/*
 * bench for dsj_unit: loads registers, runs every form, compares results.
 * assumes it is the only driver of the unit's inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module dsj_unit_tb_top;
    import dsj_pkg::*;
    // ========================================================
    // signals
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_word_valid = 1'b0;
    logic [15:0] i_word = 16'h0000;
    logic [31:0] i_pc = 32'h0000_0000;
    logic        i_zero_flag = 1'b0;
    logic        i_init_we = 1'b0;
    logic        i_init_file = 1'b0;
    logic [3:0]  i_init_idx = 4'h0;
    logic [31:0] i_init_data = 32'h0000_0000;
    logic        o_busy, o_done, o_illegal, o_taken, o_wb_valid, o_wb_file;
    logic [3:0]  o_wb_idx;
    logic [31:0] o_next_pc, o_wb_data;
    int          errors = 0;
    int          cmp_count = 0;

    dsj_unit DUT (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_word_valid(i_word_valid), .i_word(i_word), .i_pc(i_pc),
        .i_zero_flag(i_zero_flag), .i_init_we(i_init_we),
        .i_init_file(i_init_file), .i_init_idx(i_init_idx),
        .i_init_data(i_init_data), .o_busy(o_busy), .o_done(o_done),
        .o_illegal(o_illegal), .o_taken(o_taken), .o_next_pc(o_next_pc),
        .o_wb_valid(o_wb_valid), .o_wb_file(o_wb_file),
        .o_wb_idx(o_wb_idx), .o_wb_data(o_wb_data));

    // 5 ns clock
    initial
    begin
        forever #2.5 i_clk = ~i_clk;
    end

    // ========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // inputs move 1 ns after the edge, well clear of sampling
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask

    // idle gap first: a load to the written file in the write-back cycle would be dropped
    task automatic load(input logic f, input logic [3:0] r,
        input logic [31:0] d);
        step();
        i_init_we = 1'b1;
        i_init_file = f;
        i_init_idx = r;
        i_init_data = d;
        step();
        i_init_we = 1'b0;
    endtask

    // one instruction, then the results in the done cycle
    task automatic run(input logic [15:0] w1, input logic lng,
        input logic [15:0] w2, input logic [31:0] pc, input logic z,
        input logic tk, input logic [31:0] npc, input logic wb,
        input logic [31:0] d);
        int n;
        i_word_valid = 1'b1;
        i_word = w1;
        i_pc = pc;
        i_zero_flag = z;
        step();
        check(o_busy, 1'b1);
        if (lng)
        begin
            i_word = w2;
            step();
        end
        i_word_valid = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 8)
        begin
            step();
            n++;
        end
        if (n == 8)
        begin
            errors++;
            report_and_stop();
        end
        check(o_busy, 1'b0);
        check(o_taken, tk);
        check(o_next_pc, npc);
        check(o_wb_valid, wb);
        check(o_wb_data, d);
        check({o_wb_file, o_wb_idx}, w1[4:0]);
    endtask

    // ========================================================
    // scenarios
    task automatic t_illegal();
        int n;
        i_word_valid = 1'b1;
        i_word = 16'h0000;
        step();
        i_word_valid = 1'b0;
        n = 0;
        while (o_illegal !== 1'b1 && n < 3)
        begin
            step();
            n++;
        end
        if (n == 3)
        begin
            errors++;
            report_and_stop();
        end
        check(o_illegal, 1'b1);
        check(o_done, 1'b0);
    endtask

    // same index in both files keeps them apart
    task automatic t_short();
        load(1'b0, 4'h5, 32'h9);
        load(1'b1, 4'h5, 32'h1);
        run(16'h3865, 0, 0, 32'h1000, 0, 1, 32'h1040, 1, 32'h8);
        run(16'h3ff5, 0, 0, 32'h1000, 1, 0, 32'h1010, 1, 32'h0);
        run(16'h3ff5, 0, 0, 32'h1000, 0, 1, 32'h0e20, 1, '1);
        run(16'h3be5, 0, 0, 32'h1000, 0, 1, 32'h1200, 1, 32'h7);
    endtask

    task automatic t_long_ne();
        load(1'b0, 4'h2, 32'h9);
        run(16'h0dc2, 1, 16'h8000, 32'h2000, 0, 1, 32'hfff82020, 1,
            32'h8);
        run(16'h0dc2, 1, 16'h7fff, 32'h2000, 1, 0, 32'h2020, 0,
            32'h8);
        load(1'b0, 4'h2, 32'h1);
        run(16'h0dc2, 1, 16'h7fff, 32'h2000, 0, 0, 32'h2020, 1,
            32'h0);
        run(16'h0dc2, 1, 16'h7fff, 32'h2000, 0, 1, 32'h82010, 1,
            '1);
    endtask

    task automatic t_long_eq();
        load(1'b1, 4'hf, 32'h9);
        run(16'h0dbf, 1, 16'h0001, 32'h2000, 1, 1, 32'h2030, 1,
            32'h8);
        run(16'h0dbf, 1, 16'hfffe, 32'h2000, 0, 0, 32'h2020, 0,
            32'h8);
    endtask

    // ========================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge i_clk);
        #1;
        i_nrst = 1'b1;
        repeat (3) step();
        t_illegal();
        t_short();
        t_long_ne();
        t_long_eq();
        report_and_stop();
    end
endmodule
`default_nettype wire
